// ==== inc/fbc_pkg.sv ====
// shared constants and types of the flash bus command controller
package fbc_pkg;

   // user operations
   typedef enum logic [2:0] {
      OP_READ,
      OP_CMD,
      OP_IDPIN,
      OP_PROGRAM,
      OP_ERASE
   } fbc_op_type;

   // kinds of micro step inside one operation
   typedef enum logic [1:0] {
      STEP_WRITE,
      STEP_READ,
      STEP_WAIT,
      STEP_END
   } fbc_step_type;

   // widths of the flash pins, the pulse counter and the step number
   localparam int ADDR_W = 18;
   localparam int DATA_W = 8;
   localparam int CNT_W = 20;
   localparam int STEP_W = 3;

   // command byte values
   localparam logic [7:0] CMD_READ_MEMORY = 8'h00;
   localparam logic [7:0] CMD_IDENTIFIER = 8'h90;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_ERASE_VERIFY = 8'hA0;
   localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;
   localparam logic [7:0] CMD_PROGRAM_VERIFY = 8'hC0;
   localparam logic [7:0] CMD_RESET = 8'hFF;

   // pin identifier read keeps only address bit 0
   localparam logic [17:0] ID_ADDR_MASK = 18'h0_0001;

   // step numbers inside program and erase sequences
   localparam logic [2:0] STEP_SETUP_CMD = 3'h0;
   localparam logic [2:0] STEP_SECOND = 3'h1;
   localparam logic [2:0] STEP_PULSE = 3'h2;
   localparam logic [2:0] STEP_VERIFY_CMD = 3'h3;
   localparam logic [2:0] STEP_VERIFY_READ = 3'h4;

   // bus timing, times in ns, counts rounded up
   localparam int CLK_NS = 40;
   localparam int T_SETUP_NS = 80;
   localparam int T_STROBE_NS = 120;
   localparam int T_HOLD_NS = 40;
   localparam int SYNC_STAGES = 2;
   localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
   // read strobe is stretched to cover the input synchroniser
   localparam int READ_STROBE_CYC = STROBE_CYC + SYNC_STAGES;

endpackage

// ==== rtl/fbc_sync.sv ====
// two-stage synchroniser for the flash data inputs
`timescale 1ns/100ps
module fbc_sync (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // asynchronous input and synchronised output
   input wire logic [7:0] asyncIn,
   output logic [7:0] syncOut
);

   logic [7:0] stage1_reg;
   logic [7:0] stage2_reg;

   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               stage1_reg[i] <= 1'b0;
               stage2_reg[i] <= 1'b0;
            end else begin
               stage1_reg[i] <= asyncIn[i];
               stage2_reg[i] <= stage1_reg[i];
            end
         end
      end
   endgenerate

   assign syncOut = stage2_reg;

endmodule

// ==== rtl/fbc_host.sv ====
// host controller driving a byte-wide flash through its bus pins
//
// Overview of operation
// - The host loads each command by a write cycle with chip select low, output enable high, write strobe pulsed.
// - The host ends a program or erase pulse by writing the matching verify command.
// - The host treats pulse durations as minimums only.
// - Identifier voltage on address 9 with other addresses low returns maker code for A0 low, part code for A0 high.
`timescale 1ns/100ps
module fbc_host #(
   parameter int unsigned PROG_PULSE_CYC = 250,
   parameter int unsigned ERASE_PULSE_CYC = 250000
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // user request
   input wire logic reqValid,
   output logic reqReady,
   input wire fbc_pkg::fbc_op_type reqOp,
   input wire logic [17:0] reqAddr,
   input wire logic [7:0] reqData,
   // programming supply request from the system
   input wire logic supplyEnable,
   // user response
   output logic rspValid,
   output logic [7:0] rspData,
   output logic rspError,
   // flash bus pins
   output logic [17:0] flashAddr,
   input wire logic [7:0] dqIn,
   output logic [7:0] dqOut,
   output logic dqOe,
   output logic ceN,
   output logic oeN,
   output logic weN,
   output logic supplyHigh,
   output logic idVoltageA9
);

   typedef enum logic [2:0] {
      S_IDLE,
      S_NEXT,
      S_SETUP,
      S_STROBE,
      S_HOLD,
      S_PULSE
   } fbc_state_type;

   typedef struct packed {
      fbc_state_type state;
      fbc_pkg::fbc_op_type op;
      logic [2:0] step;
      logic [19:0] cnt;
      logic isWrite;
      logic [17:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic [17:0] busAddr;
      logic [7:0] dqOut;
      logic dqOe;
      logic ceN;
      logic oeN;
      logic weN;
      logic supplyHigh;
      logic idHv;
      logic rspValid;
      logic [7:0] rspData;
      logic rspError;
   } fbc_regs_type;

   fbc_regs_type r_reg;
   fbc_regs_type r_next;
   logic [7:0] dqSync;

   fbc_sync u_sync (
      .clock(clock),
      .reset_n(reset_n),
      .asyncIn(dqIn),
      .syncOut(dqSync)
   );

   // micro step sequence of each operation
   function automatic fbc_pkg::fbc_step_type stepKind(
      input fbc_pkg::fbc_op_type op,
      input logic [2:0] step
   );
      fbc_pkg::fbc_step_type k;
      k = fbc_pkg::STEP_END;
      unique case (op)
         fbc_pkg::OP_READ, fbc_pkg::OP_IDPIN: begin
            if (step == fbc_pkg::STEP_SETUP_CMD) k = fbc_pkg::STEP_READ;
         end
         fbc_pkg::OP_CMD: begin
            if (step == fbc_pkg::STEP_SETUP_CMD) k = fbc_pkg::STEP_WRITE;
         end
         fbc_pkg::OP_PROGRAM, fbc_pkg::OP_ERASE: begin
            unique case (step)
               fbc_pkg::STEP_SETUP_CMD: k = fbc_pkg::STEP_WRITE;
               fbc_pkg::STEP_SECOND: k = fbc_pkg::STEP_WRITE;
               fbc_pkg::STEP_PULSE: k = fbc_pkg::STEP_WAIT;
               fbc_pkg::STEP_VERIFY_CMD: k = fbc_pkg::STEP_WRITE;
               fbc_pkg::STEP_VERIFY_READ: k = fbc_pkg::STEP_READ;
               default: k = fbc_pkg::STEP_END;
            endcase
         end
         default: k = fbc_pkg::STEP_END;
      endcase
      return k;
   endfunction

   // byte written at a given write step
   function automatic logic [7:0] stepData(
      input fbc_pkg::fbc_op_type op,
      input logic [2:0] step,
      input logic [7:0] wdata
   );
      logic [7:0] d;
      d = wdata;
      if (op == fbc_pkg::OP_PROGRAM) begin
         if (step == fbc_pkg::STEP_SETUP_CMD) d = fbc_pkg::CMD_PROGRAM_SETUP;
         if (step == fbc_pkg::STEP_VERIFY_CMD) d = fbc_pkg::CMD_PROGRAM_VERIFY;
      end else if (op == fbc_pkg::OP_ERASE) begin
         if (step == fbc_pkg::STEP_SETUP_CMD) d = fbc_pkg::CMD_ERASE_SETUP;
         if (step == fbc_pkg::STEP_SECOND) d = fbc_pkg::CMD_ERASE_SETUP;
         if (step == fbc_pkg::STEP_VERIFY_CMD) d = fbc_pkg::CMD_ERASE_VERIFY;
      end
      return d;
   endfunction

   logic needsSupply;
   fbc_pkg::fbc_step_type curKind;

   always_comb begin
      r_next = r_reg;
      r_next.rspValid = 1'b0;
      needsSupply = (reqOp == fbc_pkg::OP_CMD) ||
                    (reqOp == fbc_pkg::OP_PROGRAM) ||
                    (reqOp == fbc_pkg::OP_ERASE);
      curKind = stepKind(r_reg.op, r_reg.step);
      unique case (r_reg.state)
         S_IDLE: begin
            // supply only switches between operations
            r_next.supplyHigh = supplyEnable;
            if (reqValid) begin
               r_next.op = reqOp;
               r_next.addr = reqAddr;
               r_next.wdata = reqData;
               r_next.step = '0;
               if (needsSupply && !r_reg.supplyHigh) begin
                  r_next.rspValid = 1'b1;
                  r_next.rspError = 1'b1;
                  r_next.rspData = '0;
               end else begin
                  r_next.state = S_NEXT;
               end
            end
         end
         S_NEXT: begin
            unique case (curKind)
               fbc_pkg::STEP_WRITE, fbc_pkg::STEP_READ: begin
                  r_next.isWrite = (curKind == fbc_pkg::STEP_WRITE);
                  r_next.ceN = 1'b0;
                  r_next.busAddr = r_reg.addr;
                  r_next.cnt = 20'(fbc_pkg::SETUP_CYC - 1);
                  r_next.state = S_SETUP;
                  if (r_reg.op == fbc_pkg::OP_IDPIN) begin
                     r_next.busAddr = r_reg.addr & fbc_pkg::ID_ADDR_MASK;
                     r_next.idHv = 1'b1;
                  end
                  // host drives data only in write cycles
                  if (curKind == fbc_pkg::STEP_WRITE) begin
                     r_next.dqOut = stepData(r_reg.op, r_reg.step, r_reg.wdata);
                     r_next.dqOe = 1'b1;
                  end
               end
               fbc_pkg::STEP_WAIT: begin
                  // pulse held at least its minimum
                  if (r_reg.op == fbc_pkg::OP_ERASE) begin
                     r_next.cnt = 20'(ERASE_PULSE_CYC - 1);
                  end else begin
                     r_next.cnt = 20'(PROG_PULSE_CYC - 1);
                  end
                  r_next.state = S_PULSE;
               end
               fbc_pkg::STEP_END: begin
                  r_next.rspValid = 1'b1;
                  r_next.rspError = 1'b0;
                  r_next.rspData = r_reg.rdata;
                  r_next.idHv = 1'b0;
                  r_next.state = S_IDLE;
               end
            endcase
         end
         S_SETUP: begin
            if (r_reg.cnt == '0) begin
               // write strobe low, output enable high
               if (r_reg.isWrite) begin
                  r_next.weN = 1'b0;
                  r_next.cnt = 20'(fbc_pkg::STROBE_CYC - 1);
               end else begin
                  // read data gated by output enable
                  r_next.oeN = 1'b0;
                  r_next.cnt = 20'(fbc_pkg::READ_STROBE_CYC - 1);
               end
               r_next.state = S_STROBE;
            end else begin
               r_next.cnt = r_reg.cnt - 20'h0_0001;
            end
         end
         S_STROBE: begin
            if (r_reg.cnt == '0) begin
               // address stable across fall, data held past rise
               r_next.weN = 1'b1;
               r_next.oeN = 1'b1;
               // verify or array data taken here
               if (!r_reg.isWrite) r_next.rdata = dqSync;
               r_next.cnt = 20'(fbc_pkg::HOLD_CYC - 1);
               r_next.state = S_HOLD;
            end else begin
               r_next.cnt = r_reg.cnt - 20'h0_0001;
            end
         end
         S_HOLD: begin
            if (r_reg.cnt == '0) begin
               r_next.ceN = 1'b1;
               r_next.dqOe = 1'b0;
               r_next.step = r_reg.step + 3'h1;
               r_next.state = S_NEXT;
            end else begin
               r_next.cnt = r_reg.cnt - 20'h0_0001;
            end
         end
         S_PULSE: begin
            // flash stays deselected while the pulse runs
            if (r_reg.cnt == '0) begin
               // verify write follows and ends the pulse
               r_next.step = r_reg.step + 3'h1;
               r_next.state = S_NEXT;
            end else begin
               r_next.cnt = r_reg.cnt - 20'h0_0001;
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         r_reg <= '{state: S_IDLE, op: fbc_pkg::OP_READ, step: '0,
                    cnt: '0, isWrite: 1'b0, addr: '0, wdata: '0,
                    rdata: '0, busAddr: '0, dqOut: '0, dqOe: 1'b0,
                    ceN: 1'b1, oeN: 1'b1, weN: 1'b1, supplyHigh: 1'b0,
                    idHv: 1'b0, rspValid: 1'b0, rspData: '0,
                    rspError: 1'b0};
      end else begin
         r_reg <= r_next;
      end
   end

   assign reqReady = (r_reg.state == S_IDLE);
   assign rspValid = r_reg.rspValid;
   assign rspData = r_reg.rspData;
   assign rspError = r_reg.rspError;
   assign flashAddr = r_reg.busAddr;
   assign dqOut = r_reg.dqOut;
   assign dqOe = r_reg.dqOe;
   assign ceN = r_reg.ceN;
   assign oeN = r_reg.oeN;
   assign weN = r_reg.weN;
   assign supplyHigh = r_reg.supplyHigh;
   assign idVoltageA9 = r_reg.idHv;

endmodule

// ==== testbench/fbc_host_checker.sv ====
// assertions on the flash bus pins of the host controller
`timescale 1ns/100ps
module fbc_host_checker (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // flash bus pins
   input wire logic [17:0] flashAddr,
   input wire logic dqOe,
   input wire logic ceN,
   input wire logic oeN,
   input wire logic weN,
   input wire logic supplyHigh,
   input wire logic idVoltageA9
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   sequence writeStrobe;
      !weN[*3] ##1 weN;
   endsequence
   sequence readStrobe;
      !oeN[*5] ##1 oeN;
   endsequence
   chk_strobe_width: assert property ($fell(weN) |-> writeStrobe)
      else $error("write strobe width wrong");
   chk_write_shape: assert property (!weN |-> !ceN && oeN && dqOe)
      else $error("write cycle pins wrong");
   chk_write_setup: assert property ($fell(weN) |-> $past(!ceN && dqOe, 2))
      else $error("address and data not set up before strobe");
   chk_write_hold: assert property ($rose(weN) |-> !ceN && dqOe && $stable(flashAddr))
      else $error("data released at strobe rise");
   chk_read_width: assert property ($fell(oeN) |-> readStrobe)
      else $error("read strobe width wrong");
   chk_no_contention: assert property (!oeN |-> !dqOe && !ceN)
      else $error("host drives data during read");
   chk_supply_block: assert property (!supplyHigh |-> weN)
      else $error("write cycle without supply");
   chk_id_address: assert property (idVoltageA9 |-> flashAddr[17:1] == 17'h0_0000 && weN)
      else $error("identifier read with other address bits set");
endmodule

bind fbc_host fbc_host_checker u_chk (.clock(clock), .reset_n(reset_n),
   .flashAddr(flashAddr), .dqOe(dqOe), .ceN(ceN), .oeN(oeN), .weN(weN),
   .supplyHigh(supplyHigh), .idVoltageA9(idVoltageA9));

// ==== testbench/fbc_flash_model.sv ====
// behavioural model of the byte-wide flash on the host's bus pins
`timescale 1ns/100ps
module fbc_flash_model #(
   // identity values are arbitrary
   parameter logic [7:0] MAKER_ID = 8'h5A,
   parameter logic [7:0] PART_ID = 8'hC3
) (
   // bus pins from the host
   input wire logic [17:0] flashAddr,
   input wire logic [7:0] dqOut,
   input wire logic dqOe,
   input wire logic ceN,
   input wire logic oeN,
   input wire logic weN,
   input wire logic supplyHigh,
   input wire logic idVoltageA9,
   // data seen by the host
   output logic [7:0] dqIn
);
   logic [7:0] mem [0:255];
   logic [7:0] cmd, rd, lastRd, wd;
   logic [17:0] la, pa;
   logic drv;
   int running;
   realtime t0, pulseNs;
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h3C;
      cmd = 8'h00;
      running = 0;
      lastRd = 8'h00;
      pulseNs = 0;
   end
   assign wd = dqOe ? dqOut : ~lastRd;
   always @(negedge supplyHigh) cmd = fbc_pkg::CMD_READ_MEMORY;
   // address at strobe fall, a write ends a pulse
   always @(negedge weN) if (!ceN) begin
      la = flashAddr;
      if (running != 0) pulseNs = $realtime - t0;
      running = 0;
   end
   // data at strobe rise steers the state machine
   always @(posedge weN) if (!ceN && supplyHigh) begin
      if (cmd == fbc_pkg::CMD_PROGRAM_SETUP) begin
         pa = la;
         mem[la[7:0]] = mem[la[7:0]] & wd;
         running = 1;
         t0 = $realtime;
         cmd = 8'h01;
      end else if (cmd == fbc_pkg::CMD_ERASE_SETUP && wd == cmd) begin
         for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
         running = 2;
         t0 = $realtime;
         cmd = 8'h02;
      end else cmd = wd;
   end
   // read source chosen by latch or identifier voltage
   always @* begin
      drv = !ceN && !oeN && weN;
      if (idVoltageA9 || cmd == fbc_pkg::CMD_IDENTIFIER)
         rd = flashAddr[0] ? PART_ID : MAKER_ID;
      else if (cmd == fbc_pkg::CMD_ERASE_VERIFY) rd = mem[la[7:0]];
      else if (cmd == fbc_pkg::CMD_PROGRAM_VERIFY) rd = mem[pa[7:0]];
      else rd = mem[flashAddr[7:0]];
      if (drv) lastRd = rd;
   end
   // released lines show the inverse of the last value
   assign dqIn = dqOe ? dqOut : (drv ? rd : ~lastRd);
endmodule

// ==== testbench/test_flash_bus_command_control.sv ====
// self-checking bench of the flash host controller against a flash model
`timescale 1ns/100ps
module test_flash_bus_command_control;
   localparam int P_PULSE = 4;
   localparam int E_PULSE = 8;
   // identity values are arbitrary
   localparam logic [7:0] MAKER_ID = 8'h5A;
   localparam logic [7:0] PART_ID = 8'hC3;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic reqValid = 1'b0;
   logic supplyEnable = 1'b0;
   fbc_pkg::fbc_op_type reqOp = fbc_pkg::OP_READ;
   logic [17:0] reqAddr = 18'h0_0000;
   logic [7:0] reqData = 8'h00;
   logic reqReady, rspValid, rspError, dqOe, ceN, oeN, weN;
   logic supplyHigh, idVoltageA9;
   logic [7:0] rspData, dqIn, dqOut;
   logic [17:0] flashAddr;
   logic [8:0] rsp;
   int miscompares = 0;
   int cmp_count = 0;
   always #20 clock = ~clock;
   fbc_host #(.PROG_PULSE_CYC(P_PULSE), .ERASE_PULSE_CYC(E_PULSE)) dut (
      .clock(clock), .reset_n(reset_n), .reqValid(reqValid),
      .reqReady(reqReady), .reqOp(reqOp), .reqAddr(reqAddr),
      .reqData(reqData), .supplyEnable(supplyEnable), .rspValid(rspValid),
      .rspData(rspData), .rspError(rspError), .flashAddr(flashAddr),
      .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .ceN(ceN), .oeN(oeN),
      .weN(weN), .supplyHigh(supplyHigh), .idVoltageA9(idVoltageA9));
   fbc_flash_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) model (
      .flashAddr(flashAddr), .dqOut(dqOut), .dqOe(dqOe), .ceN(ceN),
      .oeN(oeN), .weN(weN), .supplyHigh(supplyHigh),
      .idVoltageA9(idVoltageA9), .dqIn(dqIn));
   task automatic report_and_stop();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one request, waits for its response and keeps it in rsp
   task automatic req(input fbc_pkg::fbc_op_type op, input logic [17:0] a,
         input logic [7:0] d);
      int n;
      n = 0;
      while (reqReady !== 1'b1 && n < 400) begin
         @(posedge clock);
         #1;
         n++;
      end
      reqOp = op;
      reqAddr = a;
      reqData = d;
      reqValid = 1'b1;
      @(posedge clock);
      #1;
      reqValid = 1'b0;
      while (rspValid !== 1'b1 && n < 400) begin
         @(posedge clock);
         #1;
         n++;
      end
      if (n >= 400) begin
         miscompares++;
         report_and_stop();
      end
      rsp = {rspError, rspData};
      // let an edge pass so reqValid is never raised in the step it fell
      @(posedge clock);
      #1;
   endtask
   task automatic set_supply(input logic on);
      supplyEnable = on;
      repeat (2) @(posedge clock);
      #1;
   endtask
   task automatic t_read_only();
      req(fbc_pkg::OP_READ, 18'h0_0005, 8'h00);
      check(rsp, {1'b0, 8'h05 ^ 8'h3C});
      req(fbc_pkg::OP_IDPIN, 18'h0_0001, 8'h00);
      check(rsp, {1'b0, PART_ID});
      req(fbc_pkg::OP_IDPIN, 18'h0_0000, 8'h00);
      check(rsp, {1'b0, MAKER_ID});
      req(fbc_pkg::OP_PROGRAM, 18'h0_0005, 8'h00);
      check(rsp, 9'h100);
      req(fbc_pkg::OP_READ, 18'h0_0005, 8'h00);
      check(rsp, {1'b0, 8'h05 ^ 8'h3C});
   endtask
   task automatic t_program();
      set_supply(1'b1);
      req(fbc_pkg::OP_PROGRAM, 18'h0_0007, 8'h12);
      check(rsp, {1'b0, (8'h07 ^ 8'h3C) & 8'h12});
      check({8'h00, model.pulseNs >= P_PULSE * 40}, 9'h001);
      req(fbc_pkg::OP_CMD, 18'h0_0000, fbc_pkg::CMD_READ_MEMORY);
      req(fbc_pkg::OP_READ, 18'h0_0007, 8'h00);
      check(rsp, {1'b0, (8'h07 ^ 8'h3C) & 8'h12});
   endtask
   task automatic t_identifier();
      req(fbc_pkg::OP_CMD, 18'h0_0000, fbc_pkg::CMD_IDENTIFIER);
      req(fbc_pkg::OP_READ, 18'h0_0001, 8'h00);
      check(rsp, {1'b0, PART_ID});
      req(fbc_pkg::OP_READ, 18'h0_0000, 8'h00);
      check(rsp, {1'b0, MAKER_ID});
      req(fbc_pkg::OP_CMD, 18'h0_0000, fbc_pkg::CMD_RESET);
      req(fbc_pkg::OP_CMD, 18'h0_0000, fbc_pkg::CMD_RESET);
      req(fbc_pkg::OP_CMD, 18'h0_0000, fbc_pkg::CMD_READ_MEMORY);
      req(fbc_pkg::OP_READ, 18'h0_0004, 8'h00);
      check(rsp, {1'b0, 8'h04 ^ 8'h3C});
   endtask
   task automatic t_erase();
      req(fbc_pkg::OP_ERASE, 18'h0_0007, 8'h00);
      check(rsp, 9'h0FF);
      check({8'h00, model.pulseNs >= E_PULSE * 40}, 9'h001);
      set_supply(1'b0);
      req(fbc_pkg::OP_CMD, 18'h0_0000, fbc_pkg::CMD_IDENTIFIER);
      check(rsp, 9'h100);
      req(fbc_pkg::OP_READ, 18'h0_0005, 8'h00);
      check(rsp, 9'h0FF);
   endtask
   // reset in the first cycle of a read strobe, just after output enable falls, then a clean read
   task automatic t_reset();
      reqOp = fbc_pkg::OP_READ;
      reqAddr = 18'h0_0006;
      reqData = 8'h00;
      reqValid = 1'b1;
      @(posedge clock);
      #1;
      reqValid = 1'b0;
      repeat (3) @(posedge clock);
      #1;
      reset_n = 1'b0;
      #1;
      check({4'h0, ceN, oeN, weN, dqOe, reqReady}, 9'h01D);
      repeat (2) @(posedge clock);
      #1;
      check({8'h00, supplyHigh}, 9'h000);
      reset_n = 1'b1;
      @(posedge clock);
      #1;
      req(fbc_pkg::OP_READ, 18'h0_0006, 8'h00);
      check(rsp, 9'h0FF);
   endtask
   initial begin
      repeat (8) @(posedge clock);
      #1;
      reset_n = 1'b1;
      @(posedge clock);
      #1;
      t_read_only();
      t_program();
      t_identifier();
      t_erase();
      t_reset();
      report_and_stop();
   end
endmodule
